// ==== rtl/rie_irq_ctrl.sv ====
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
module rie_irq_ctrl #(
    parameter int CMD_W = 4
) (
    input  wire logic             REF_CLK,
    input  wire logic             SYS_RST,
    input  wire logic             CLK_EN,
    // Wishbone classic slave.
    input  wire logic             WB_CYC_I,
    input  wire logic             WB_STB_I,
    input  wire logic             WB_WE_I,
    input  wire logic [7:0]       WB_ADR_I,
    input  wire logic [3:0]       WB_SEL_I,
    input  wire logic [31:0]      WB_DAT_I,
    output logic      [31:0]      WB_DAT_O,
    output logic                  WB_ACK_O,
    // Source events from the rest of the reader, same clock.
    input  wire logic             TX_LAST_BIT_SENT,
    input  wire logic             RX_STREAM_END,
    input  wire logic             RX_FIFO_NOT_EMPTY,
    input  wire logic             SUPPRESS_EMPTY_FRAME,
    input  wire logic             CMD_TERMINATED,
    input  wire logic             CMD_UNKNOWN,
    input  wire logic             FIFO_HIGH_LEVEL_STATUS,
    input  wire logic             FIFO_LOW_LEVEL_STATUS,
    input  wire logic [7:0]       ERROR_STATUS,
    input  wire logic             TIMER_AT_ZERO,
    input  wire logic             CHECKSUM_COMPUTE_CMD,
    input  wire logic             CHECKSUM_DATA_DONE,
    // Pin from outside the clock domain.
    input  wire logic             AUX_SERIAL_INPUT,
    // Interrupt pin, three signals; enable low means driven.
    input  wire logic             IRQ_PIN_I,
    output logic                  IRQ_PIN_O,
    output logic                  IRQ_PIN_OE_N,
    output logic [CMD_W-1:0]      CMD_FIELD
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0]       com_en_q;
    logic [7:0]       aux_en_q;
    logic [7:0]       com_req_q;
    logic [7:0]       aux_req_q;
    logic [CMD_W-1:0] cmd_q;
    logic             aux_s1_q;
    logic             aux_s2_q;
    logic             aux_s3_q;
    logic             hi_prev_q;
    logic             lo_prev_q;
    logic [7:0]       err_prev_q;
    logic             irq_agg;
    logic             pin_lvl;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic       req;
    logic       wr;
    logic [3:0] idx;
    assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wr  = req & WB_WE_I & WB_SEL_I[0];
    assign idx = WB_ADR_I[5:2];

    // Set/clear write convention shared by both request registers.
    function automatic logic [7:0] set_clear(input logic [7:0] cur, input logic [7:0] wd,
                                             input logic [7:0] mask);
        logic [7:0] marked;
        marked = wd & mask;
        if (wd[rie_pkg::SET_CLEAR_BIT]) begin
            set_clear = cur | marked;
        end else begin
            set_clear = cur & ~marked;
        end
    endfunction

    // ------------------------------------------------------------------
    // Source event detection
    // ------------------------------------------------------------------
    logic [7:0] com_evt;
    logic [7:0] aux_evt;
    logic       host_idle_wr;
    // A host write of idle is not a command end; unknown starts are.
    assign host_idle_wr = wr && idx == rie_pkg::CMD_CTRL_IDX;
    always_comb begin
        com_evt = 8'h00;
        com_evt[rie_pkg::TX_DONE_BIT]        = TX_LAST_BIT_SENT;
        com_evt[rie_pkg::RX_DONE_BIT]        = RX_STREAM_END &
            (~SUPPRESS_EMPTY_FRAME | RX_FIFO_NOT_EMPTY);
        com_evt[rie_pkg::CMD_END_BIT]        = (CMD_TERMINATED & ~host_idle_wr)
            | CMD_UNKNOWN;
        com_evt[rie_pkg::FIFO_HIGH_BIT]      = FIFO_HIGH_LEVEL_STATUS & ~hi_prev_q;
        com_evt[rie_pkg::FIFO_LOW_BIT]       = FIFO_LOW_LEVEL_STATUS & ~lo_prev_q;
        com_evt[rie_pkg::FAULT_BIT]          = |(ERROR_STATUS & ~err_prev_q);
        com_evt[rie_pkg::COUNTDOWN_ZERO_BIT] = TIMER_AT_ZERO;
        aux_evt = 8'h00;
        aux_evt[rie_pkg::AUX_EDGE_BIT] = aux_s2_q ^ aux_s3_q;
        aux_evt[rie_pkg::CHECKSUM_BIT] = CHECKSUM_COMPUTE_CMD & CHECKSUM_DATA_DONE;
    end

    // Aux input synchroniser; third stage only feeds the edge compare.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            aux_s1_q <= 1'b0;
            aux_s2_q <= 1'b0;
            aux_s3_q <= 1'b0;
        end else if (CLK_EN) begin
            aux_s1_q <= AUX_SERIAL_INPUT;
            aux_s2_q <= aux_s1_q;
            aux_s3_q <= aux_s2_q;
        end
    end

    // Previous levels for the level-to-event edge detectors.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            hi_prev_q  <= 1'b0;
            lo_prev_q  <= 1'b0;
            err_prev_q <= 8'h00;
        end else if (CLK_EN) begin
            hi_prev_q  <= FIFO_HIGH_LEVEL_STATUS;
            lo_prev_q  <= FIFO_LOW_LEVEL_STATUS;
            err_prev_q <= ERROR_STATUS;
        end
    end

    // ------------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            com_en_q <= rie_pkg::COMMON_ENABLE_RESET;
            aux_en_q <= rie_pkg::AUX_ENABLE_RESET;
        end else if (CLK_EN && wr) begin
            if (idx == rie_pkg::COMMON_IRQ_ENABLE_IDX) begin
                com_en_q <= WB_DAT_I[7:0];
            end
            // Reserved bits stay zero so they read back as zero.
            if (idx == rie_pkg::AUX_IRQ_ENABLE_IDX) begin
                aux_en_q <= WB_DAT_I[7:0] & rie_pkg::AUX_ENABLE_MASK;
            end
        end
    end

    // ------------------------------------------------------------------
    // Request flags: events win over a same-cycle host clear.
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            com_req_q <= rie_pkg::COMMON_REQUEST_RESET;
            aux_req_q <= rie_pkg::AUX_REQUEST_RESET;
        end else if (CLK_EN) begin
            // Only host writes clear; sources set independent of enables.
            if (wr && idx == rie_pkg::COMMON_IRQ_REQUEST_IDX) begin
                com_req_q <= set_clear(com_req_q, WB_DAT_I[7:0], rie_pkg::COMMON_FLAG_MASK)
                    | com_evt;
            end else begin
                com_req_q <= com_req_q | com_evt;
            end
            if (wr && idx == rie_pkg::AUX_IRQ_REQUEST_IDX) begin
                aux_req_q <= set_clear(aux_req_q, WB_DAT_I[7:0], rie_pkg::AUX_FLAG_MASK)
                    | aux_evt;
            end else begin
                aux_req_q <= aux_req_q | aux_evt;
            end
        end
    end

    // ------------------------------------------------------------------
    // Command field: unknown starts fall back to idle.
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            cmd_q <= CMD_W'(rie_pkg::CMD_CTRL_RESET);
        end else if (CLK_EN) begin
            if (CMD_UNKNOWN || CMD_TERMINATED) begin
                cmd_q <= CMD_W'(rie_pkg::CMD_IDLE);
            end else if (wr && idx == rie_pkg::CMD_CTRL_IDX) begin
                cmd_q <= WB_DAT_I[CMD_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Aggregate status and pin drive
    // ------------------------------------------------------------------
    // Bit 7 of each request register is not a flag, so it is masked off.
    assign irq_agg = |(com_req_q & com_en_q & rie_pkg::COMMON_FLAG_MASK)
                   | |(aux_req_q & aux_en_q & rie_pkg::AUX_FLAG_MASK);

    // Level the pin should show before the output style is applied.
    assign pin_lvl = com_en_q[rie_pkg::POLARITY_BIT] ? ~irq_agg : irq_agg;

    // Pin is registered, so it trails the flags by one cycle.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            IRQ_PIN_O    <= 1'b0;
            IRQ_PIN_OE_N <= 1'b1;
        end else if (CLK_EN) begin
            if (aux_en_q[rie_pkg::DRIVE_STYLE_BIT]) begin
                IRQ_PIN_O    <= pin_lvl;
                IRQ_PIN_OE_N <= 1'b0;
            end else begin
                // Open drain only pulls low; high is left to the pull-up.
                IRQ_PIN_O    <= 1'b0;
                IRQ_PIN_OE_N <= pin_lvl;
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus answer: one wait state, unmapped reads give zero.
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else if (CLK_EN) begin
            WB_ACK_O <= req;
            WB_DAT_O <= 32'h0000_0000;
            if (req && !WB_WE_I) begin
                unique case (idx)
                    rie_pkg::COMMON_IRQ_ENABLE_IDX:  WB_DAT_O[7:0] <= com_en_q;
                    rie_pkg::AUX_IRQ_ENABLE_IDX:     WB_DAT_O[7:0] <= aux_en_q;
                    rie_pkg::COMMON_IRQ_REQUEST_IDX: WB_DAT_O[7:0] <= com_req_q;
                    rie_pkg::AUX_IRQ_REQUEST_IDX:    WB_DAT_O[7:0] <= aux_req_q;
                    rie_pkg::CMD_CTRL_IDX:           WB_DAT_O[7:0] <= 8'(cmd_q);
                    rie_pkg::IRQ_STATUS_IDX: begin
                        WB_DAT_O[rie_pkg::STATUS_IRQ_BIT] <= irq_agg;
                        WB_DAT_O[0] <= IRQ_PIN_I;
                    end
                    default:                         WB_DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Command field mirror for the sequencer.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            CMD_FIELD <= '0;
        end else if (CLK_EN) begin
            CMD_FIELD <= cmd_q;
        end
    end

endmodule

// ==== rtl/rie_pkg.sv ====
package rie_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [3:0] COMMON_IRQ_ENABLE_IDX  = 4'h2;
    localparam logic [3:0] AUX_IRQ_ENABLE_IDX     = 4'h3;
    localparam logic [3:0] COMMON_IRQ_REQUEST_IDX = 4'h4;
    localparam logic [3:0] AUX_IRQ_REQUEST_IDX    = 4'h5;
    localparam logic [3:0] IRQ_STATUS_IDX         = 4'h7;
    localparam logic [3:0] CMD_CTRL_IDX           = 4'h1;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SET_CLEAR_BIT      = 7;
    localparam int POLARITY_BIT       = 7;
    localparam int DRIVE_STYLE_BIT    = 7;
    localparam int TX_DONE_BIT        = 6;
    localparam int RX_DONE_BIT        = 5;
    localparam int CMD_END_BIT        = 4;
    localparam int FIFO_HIGH_BIT      = 3;
    localparam int FIFO_LOW_BIT       = 2;
    localparam int FAULT_BIT          = 1;
    localparam int COUNTDOWN_ZERO_BIT = 0;
    localparam int AUX_EDGE_BIT       = 4;
    localparam int CHECKSUM_BIT       = 2;
    localparam int STATUS_IRQ_BIT     = 4;
    localparam int SUPPRESS_EMPTY_BIT = 4;

    // ------------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] COMMON_ENABLE_RESET  = 8'h80;
    localparam logic [7:0] AUX_ENABLE_RESET     = 8'h00;
    localparam logic [7:0] COMMON_REQUEST_RESET = 8'h14;
    localparam logic [7:0] AUX_REQUEST_RESET    = 8'h00;
    localparam logic [7:0] CMD_CTRL_RESET       = 8'h00;
    localparam logic [7:0] COMMON_FLAG_MASK     = 8'h7f;
    localparam logic [7:0] AUX_FLAG_MASK        = 8'h14;
    localparam logic [7:0] AUX_ENABLE_MASK      = 8'h94;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_IDLE = 4'h0;

endpackage

// ==== verification/rie_host_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------
// Host: Wishbone master and the pulled-up IRQ wire.
// ------------------------------------------------
module rie_host_model (
    input wire logic    clk,
    input wire logic    ack,
    input wire logic    pin_o,
    input wire logic    pin_oe_n,
    output logic        cyc = 1'b0,
    output logic        stb = 1'b0,
    output logic        we  = 1'b0,
    output logic [7:0]  adr = 8'h00,
    output logic [31:0] dat = 32'h0,
    output logic [3:0]  sel = 4'h0,
    output logic        pin_level
);
    // Byte lanes for the next transfer; the bench may drop lane 0 to test refusal.
    logic [3:0] lanes = 4'h1;
    // The board pull-up wins whenever the pin is released.
    assign pin_level = pin_oe_n ? 1'b1 : pin_o;
    // Everything is held until ack is seen, so slow answers are fine.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h0, d};
        sel <= lanes;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Bit 7 picks set or clear for the marked bits.
    task automatic set_clr(input logic [7:0] a, input logic s, input logic [6:0] m);
        xfer(1'b1, a, {s, m});
    endtask
endmodule

// ==== verification/rie_irq_ctrl_properties.sv ====
`timescale 1ns/1ps
// ------------------------------
// Port checks of the controller.
// ------------------------------
module rie_irq_ctrl_properties #(
    parameter int CMD_W = 4
) (
    input wire logic             REF_CLK,
    input wire logic             SYS_RST,
    input wire logic             CLK_EN,
    input wire logic             WB_CYC_I,
    input wire logic             WB_STB_I,
    input wire logic             WB_WE_I,
    input wire logic [7:0]       WB_ADR_I,
    input wire logic [31:0]      WB_DAT_O,
    input wire logic             WB_ACK_O,
    input wire logic             CMD_TERMINATED,
    input wire logic             CMD_UNKNOWN,
    input wire logic [CMD_W-1:0] CMD_FIELD,
    input wire logic             IRQ_PIN_O,
    input wire logic             IRQ_PIN_OE_N
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    // A request counts only while the slave is idle and the clock is enabled.
    sequence s_take;
        WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN;
    endsequence
    sequence s_read_hole;
        s_take ##0 (!WB_WE_I && WB_ADR_I[5:2] inside {4'h0, 4'h6, [4'h8:4'hf]});
    endsequence
    property p_ack_after_take; s_take |=> WB_ACK_O; endproperty
    property p_ack_pulse; WB_ACK_O && CLK_EN |=> !WB_ACK_O; endproperty
    property p_ack_cause; $rose(WB_ACK_O) |-> $past(WB_CYC_I) && $past(WB_STB_I); endproperty
    property p_dat_high; WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0; endproperty
    property p_read_hole; s_read_hole |=> WB_ACK_O && WB_DAT_O == 32'h0; endproperty
    // The field output is a registered copy, so it shows idle two enabled edges later.
    property p_unknown_idle; CMD_UNKNOWN && CLK_EN ##1 CLK_EN |=> CMD_FIELD == '0; endproperty
    property p_term_idle; CMD_TERMINATED && CLK_EN ##1 CLK_EN |=> CMD_FIELD == '0; endproperty
    property p_released_low; IRQ_PIN_OE_N |-> !IRQ_PIN_O; endproperty
    property p_freeze;
        !CLK_EN |=> $stable({WB_ACK_O, IRQ_PIN_O, IRQ_PIN_OE_N, CMD_FIELD});
    endproperty
    a_ack_after_take: assert property (p_ack_after_take) else $error("no ack after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_dat_high: assert property (p_dat_high) else $error("upper read data not zero");
    a_read_hole: assert property (p_read_hole) else $error("unmapped read not zero");
    a_unknown_idle: assert property (p_unknown_idle)
        else $error("unknown command left field busy");
    a_term_idle: assert property (p_term_idle)
        else $error("ended command left field busy");
    a_released_low: assert property (p_released_low)
        else $error("released pin carries high data");
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");
endmodule
bind rie_irq_ctrl rie_irq_ctrl_properties #(.CMD_W(CMD_W)) u_props (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .CMD_TERMINATED(CMD_TERMINATED), .CMD_UNKNOWN(CMD_UNKNOWN),
    .CMD_FIELD(CMD_FIELD), .IRQ_PIN_O(IRQ_PIN_O), .IRQ_PIN_OE_N(IRQ_PIN_OE_N));

// ==== verification/rie_irq_ctrl_tb.sv ====
`timescale 1ns/1ps
module rie_irq_ctrl_tb;
    logic        ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
    logic        tx = 1'b0, rxe = 1'b0, rxne = 1'b0, sup = 1'b0, term = 1'b0, unk = 1'b0;
    logic        fh = 1'b0, fl = 1'b0, tmr = 1'b0, ccmd = 1'b0, cdone = 1'b0, aux = 1'b0;
    logic [7:0]  err = 8'h00, adr, r;
    logic        cyc, stb, we, ack, pin_o, pin_oe_n, lvl;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [3:0]  cmd;
    logic [7:0]  expq[$];
    int          n_mismatch = 0, checks_done = 0, seed = 88;

    initial forever #12.5 ref_clk = ~ref_clk;

    rie_irq_ctrl u_dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .TX_LAST_BIT_SENT(tx),
        .RX_STREAM_END(rxe), .RX_FIFO_NOT_EMPTY(rxne), .SUPPRESS_EMPTY_FRAME(sup),
        .CMD_TERMINATED(term), .CMD_UNKNOWN(unk), .FIFO_HIGH_LEVEL_STATUS(fh),
        .FIFO_LOW_LEVEL_STATUS(fl), .ERROR_STATUS(err), .TIMER_AT_ZERO(tmr),
        .CHECKSUM_COMPUTE_CMD(ccmd), .CHECKSUM_DATA_DONE(cdone), .AUX_SERIAL_INPUT(aux),
        .IRQ_PIN_I(lvl), .IRQ_PIN_O(pin_o), .IRQ_PIN_OE_N(pin_oe_n), .CMD_FIELD(cmd));
    rie_host_model u_host (.clk(ref_clk), .ack(ack), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat(wdat), .sel(sel), .pin_level(lvl));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        u_host.xfer(1'b0, a, 8'h00);
    endtask
    // The pin is looked at mid-cycle, clear of the edge that moves it.
    task automatic pin(input logic oe_n, input logic l);
        @(negedge ref_clk);
        chk({7'h0, pin_oe_n}, {7'h0, oe_n});
        chk({7'h0, lvl}, {7'h0, l});
        @(posedge ref_clk);
    endtask
    // Fire one source by its flag position; 7 is the unknown-command pulse.
    task automatic fire(input int b);
        @(posedge ref_clk);
        case (b)
            7: unk <= 1'b1;
            6: tx <= 1'b1;
            5: rxe <= 1'b1;
            4: term <= 1'b1;
            3: fh <= 1'b1;
            2: fl <= 1'b1;
            1: err <= 8'h20;
            default: tmr <= 1'b1;
        endcase
        @(posedge ref_clk);
        {unk, tx, rxe, term, fh, fl, err, tmr} <= '0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Each read answer retires the oldest expectation.
    always @(posedge ref_clk) begin
        if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
            if (expq.size() > 0) chk(rdat[7:0], expq.pop_front());
            else chk(8'h00, 8'hff);
        end
    end

    // Watchdog, far beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge ref_clk);
        $display("ERROR %0t: watchdog expired", $time);
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(8'h08, 8'h80);
        rd(8'h0c, 8'h00);
        rd(8'h10, 8'h14);
        pin(1'b1, 1'b1);
        $display("test reset done");
        for (int b = 0; b < 8; b++) begin
            u_host.set_clr(8'h10, 1'b0, 7'h7f);
            fire(b);
            rd(8'h10, (b == 7) ? 8'h10 : 8'h01 << b);
        end
        // A busy command must fall back to idle when an unknown one starts.
        u_host.xfer(1'b1, 8'h04, 8'h0c);
        @(negedge ref_clk);
        chk({4'h0, cmd}, 8'h0c);
        fire(7);
        @(negedge ref_clk);
        @(negedge ref_clk);
        chk({4'h0, cmd}, 8'h00);
        @(posedge ref_clk);
        sup <= 1'b1;
        fire(5);
        rd(8'h10, 8'h10);
        rxne <= 1'b1;
        fire(5);
        u_host.set_clr(8'h10, 1'b0, 7'h10);
        // A termination in the very cycle the host writes idle must not flag.
        fork
            u_host.xfer(1'b1, 8'h04, 8'h00);
            begin
                @(posedge ref_clk);
                term <= 1'b1;
                @(posedge ref_clk);
                term <= 1'b0;
            end
        join
        rd(8'h10, 8'h20);
        u_host.set_clr(8'h10, 1'b1, 7'h7f);
        u_host.set_clr(8'h10, 1'b0, 7'h0f);
        repeat (50) @(posedge ref_clk);
        rd(8'h10, 8'h70);
        $display("test flags done");
        u_host.xfer(1'b1, 8'h08, 8'hc0);
        pin(1'b0, 1'b0);
        rd(8'h1c, 8'h10);
        u_host.xfer(1'b1, 8'h08, 8'h40);
        pin(1'b1, 1'b1);
        u_host.xfer(1'b1, 8'h0c, 8'h80);
        pin(1'b0, 1'b1);
        u_host.xfer(1'b1, 8'h08, 8'h0f);
        pin(1'b0, 1'b0);
        rd(8'h1c, 8'h00);
        aux <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rd(8'h14, 8'h10);
        u_host.set_clr(8'h14, 1'b0, 7'h14);
        aux <= 1'b0;
        ccmd <= 1'b1;
        cdone <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rd(8'h14, 8'h14);
        {ccmd, cdone} <= 2'b00;
        u_host.xfer(1'b1, 8'h0c, 8'h90);
        pin(1'b0, 1'b1);
        u_host.set_clr(8'h14, 1'b0, 7'h10);
        pin(1'b0, 1'b0);
        u_host.xfer(1'b1, 8'h0c, 8'h84);
        pin(1'b0, 1'b1);
        $display("test pin done");
        u_host.xfer(1'b1, 8'h18, 8'h5a);
        rd(8'h18, 8'h00);
        for (int i = 0; i < 4; i++) begin
            r = 8'($random(seed));
            u_host.xfer(1'b1, 8'h08, r);
            rd(8'h08, r);
            u_host.xfer(1'b1, 8'h0c, r);
            rd(8'h0c, r & 8'h94);
        end
        // A write without byte lane 0 is answered but must not land.
        u_host.lanes = 4'h0;
        u_host.xfer(1'b1, 8'h08, ~r);
        u_host.lanes = 4'h1;
        rd(8'h08, r);
        clk_en <= 1'b0;
        repeat (3) @(posedge ref_clk);
        clk_en <= 1'b1;
        rd(8'h0c, r & 8'h94);
        $display("test access done");
        @(posedge ref_clk);
        final_report();
    end
endmodule
